// File: rtl/tcs_regs.svh
// Register offsets, field positions and timing constants
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_CLK_NS      100'd10
`define TCS_SEC_NS      100'd1000000000
`define TCS_PFAIL_NS    100'd30000000
`define TCS_A_CFG       8'h00
`define TCS_A_SETT      8'h04
`define TCS_A_CODE      8'h08
`define TCS_A_UNLK      8'h0c
`define TCS_A_TIME      8'h10
`define TCS_A_SYNC      8'h14
`define TCS_A_SCHED     8'h18
`define TCS_A_STAT      8'h28
`define TCS_A_TCNT      8'h2c
`define TCS_CFG_CLOCK   0
`define TCS_CFG_FMT24   1
`define TCS_CFG_DOWN    2
`define TCS_CFG_REPEAT  3
`define TCS_CFG_LTRE    14
`define TCS_CFG_EN1     15
`define TCS_CFG_EN2     16
`define TCS_CFG_FSMASK  17'h1bffc
`define TCS_CFG_RST     17'h00000
`define TCS_CODE_OPEN   16'h0000
`define TCS_HDAY        5'h18
`define TCS_HHALF       5'h0c
`define TCS_MLAST       6'h3b
`endif

// File: rtl/tcs_pkg.sv
// Shared types of the timer and clock supervisor
package tcs_pkg;
    typedef enum logic [2:0] {
        TS_READY, TS_RUN, TS_PAUSE, TS_DONE, TS_FSAFE
    } tcs_tstate_t;
endpackage

// File: rtl/tcs_top.sv
// Timer and time-of-day clock supervisor with register port
`include "tcs_regs.svh"
module tcs_top #(
    parameter int TICK_CYC  = int'(`TCS_SEC_NS / `TCS_CLK_NS),
    parameter int PFAIL_CYC = int'(`TCS_PFAIL_NS / `TCS_CLK_NS)
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_start,
    input  wire logic        i_stop,
    input  wire logic        i_local_reset,
    input  wire logic        i_contact,
    input  wire logic        i_supply_ok,
    output logic      [31:0] o_rdata,
    output logic             o_out1,
    output logic             o_out2,
    output logic      [4:0]  o_hour,
    output logic      [5:0]  o_min,
    output logic      [5:0]  o_sec,
    output logic             o_pm,
    output logic             o_flash,
    output logic             o_sync_active
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam int FW = $clog2(PFAIL_CYC + 1);

    typedef struct packed {
        logic [16:0]       cfg;
        logic [16:0]       sett;
        logic [15:0]       code;
        logic              unlk;
        tcs_pkg::tcs_tstate_t tst;
        logic [16:0]       tcnt;
        logic [4:0]        hh;
        logic [5:0]        mm;
        logic [5:0]        ss;
        logic              cset;
        logic              cprev;
        logic [FW-1:0]     pf;
        logic [3:0][21:0]  sched;
        logic [16:0]       sync;
        logic              o1;
        logic              o2;
        logic [4:0]        dhour;
        logic              pm;
        logic [31:0]       rdata;
        logic [PW-1:0]     pre;
    } tcs_state_t;

    tcs_state_t st_r, st_nxt;
    logic tick, clk_mode, tdown, trst, open_code;
    logic [16:0] tend;
    logic [10:0] now_hm;
    logic [1:0]  outv;

    assign tick      = st_r.pre == PW'(TICK_CYC - 1);
    assign clk_mode  = st_r.cfg[`TCS_CFG_CLOCK];
    assign open_code = st_r.code == `TCS_CODE_OPEN;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = '0;
        st_nxt.pre = tick ? '0 : st_r.pre + PW'(1);
        // Registers
        if (i_wr) begin
            unique case (i_addr)
                `TCS_A_CFG: begin
                    if (!i_wdata[`TCS_CFG_CLOCK] &&
                        ((i_wdata[16:0] ^ st_r.cfg) & `TCS_CFG_FSMASK) != '0)
                        st_nxt.tst = tcs_pkg::TS_FSAFE;
                    st_nxt.cfg = i_wdata[16:0];
                end
                `TCS_A_SETT: st_nxt.sett = i_wdata[16:0];
                // code changes only when access is open
                `TCS_A_CODE: if (st_r.unlk || open_code)
                    st_nxt.code = i_wdata[15:0];
                `TCS_A_UNLK: st_nxt.unlk = i_wdata[15:0] == st_r.code;
                `TCS_A_SYNC: st_nxt.sync = {i_wdata[20:16], i_wdata[13:8],
                                            i_wdata[5:0]};
                default: begin
                    if (i_addr >= `TCS_A_SCHED && i_addr < `TCS_A_STAT)
                        st_nxt.sched[i_addr[3:2] - 2'(`TCS_A_SCHED >> 2)] =
                            {i_wdata[26:16], i_wdata[10:0]};
                end
            endcase
        end
        // Direction and end point follow the committed configuration
        tdown = st_nxt.cfg[`TCS_CFG_DOWN];
        tend  = tdown ? '0 : st_nxt.sett;
        trst  = (!clk_mode && i_contact) ||
                (i_local_reset && st_r.cfg[`TCS_CFG_LTRE]);
        // Timer
        if (!clk_mode) begin
            unique case (st_nxt.tst)
                tcs_pkg::TS_READY: begin
                    // no start on zero set time
                    // Load the start point so a down count never wraps
                    if (i_start && st_r.sett != '0) begin
                        st_nxt.tst  = tcs_pkg::TS_RUN;
                        st_nxt.tcnt = tdown ? st_r.sett : '0;
                    end
                end
                tcs_pkg::TS_RUN: begin
                    if (i_stop)
                        st_nxt.tst = tcs_pkg::TS_PAUSE;
                    else if (tick) begin
                        st_nxt.tcnt = tdown ? st_r.tcnt - 17'h1
                                            : st_r.tcnt + 17'h1;
                        if (st_nxt.tcnt == tend)
                            st_nxt.tst = st_r.cfg[`TCS_CFG_REPEAT]
                                ? tcs_pkg::TS_READY : tcs_pkg::TS_DONE;
                        if (st_nxt.tcnt == tend &&
                            st_r.cfg[`TCS_CFG_REPEAT])
                            st_nxt.tcnt = tdown ? st_r.sett : '0;
                    end
                end
                tcs_pkg::TS_PAUSE:
                    if (i_start) st_nxt.tst = tcs_pkg::TS_RUN;
                tcs_pkg::TS_DONE: st_nxt.tst = tcs_pkg::TS_DONE;
                tcs_pkg::TS_FSAFE: st_nxt.tcnt = tend;
            endcase
            if (trst) begin
                st_nxt.tst  = tcs_pkg::TS_READY;
                st_nxt.tcnt = tdown ? st_nxt.sett : '0;
            end
        end
        // Clock
        st_nxt.cprev = i_contact;
        if (clk_mode) begin
            if (i_contact) begin
                {st_nxt.hh, st_nxt.mm, st_nxt.ss} = st_r.sync;
            end else if (st_r.cprev) begin
                st_nxt.cset = 1'b1;
            end else if (i_wr && i_addr == `TCS_A_TIME &&
                         (st_r.unlk || open_code)) begin
                st_nxt.hh   = i_wdata[20:16];
                st_nxt.mm   = i_wdata[13:8];
                st_nxt.ss   = i_wdata[5:0];
                st_nxt.cset = 1'b1;
            end else if (tick && st_r.cset) begin
                st_nxt.ss = st_r.ss + 6'h1;
                if (st_r.ss == `TCS_MLAST) begin
                    st_nxt.ss = '0;
                    st_nxt.mm = st_r.mm + 6'h1;
                    if (st_r.mm == `TCS_MLAST) begin
                        st_nxt.mm = '0;
                        st_nxt.hh = st_r.hh + 5'h1;
                        if (st_r.hh == `TCS_HDAY - 5'h1)
                            st_nxt.hh = '0;
                    end
                end
            end
        end
        // long supply dip loses the time
        st_nxt.pf = i_supply_ok ? '0 :
                    (st_r.pf == FW'(PFAIL_CYC) ? st_r.pf : st_r.pf + FW'(1));
        if (st_nxt.pf == FW'(PFAIL_CYC))
            st_nxt.cset = 1'b0;
        now_hm = {st_nxt.hh, st_nxt.mm};
        outv = {st_r.o2, st_r.o1};
        for (int k = 0; k < 2; k++) begin
            for (int p = 0; p < 2; p++) begin
                if (st_nxt.ss == '0 && st_nxt.ss != st_r.ss) begin
                    if (now_hm == st_r.sched[2*k+p][10:0]) outv[k] = 1'b1;
                    if (now_hm == st_r.sched[2*k+p][21:11]) outv[k] = 1'b0;
                end
            end
        end
        if (!clk_mode)
            outv = {st_nxt.tst == tcs_pkg::TS_DONE,
                    st_nxt.tst == tcs_pkg::TS_RUN};
        st_nxt.o1 = outv[0] && st_r.cfg[`TCS_CFG_EN1];
        st_nxt.o2 = outv[1] && st_r.cfg[`TCS_CFG_EN2];
        st_nxt.pm = st_nxt.hh >= `TCS_HHALF;
        st_nxt.dhour = st_nxt.hh;
        if (!st_r.cfg[`TCS_CFG_FMT24]) begin
            if (st_nxt.hh == '0)
                st_nxt.dhour = `TCS_HHALF;
            else if (st_nxt.hh > `TCS_HHALF)
                st_nxt.dhour = st_nxt.hh - `TCS_HHALF;
        end
        if (i_rd) begin
            unique case (i_addr)
                `TCS_A_CFG:  st_nxt.rdata = {15'h0, st_r.cfg};
                `TCS_A_SETT: st_nxt.rdata = {15'h0, st_r.sett};
                `TCS_A_TIME: st_nxt.rdata = {11'h0, st_r.hh, 2'h0,
                                             st_r.mm, 2'h0, st_r.ss};
                `TCS_A_STAT: st_nxt.rdata = {24'h0, i_contact, st_r.o2,
                                             st_r.o1, st_r.unlk, st_r.cset,
                                             st_r.tst};
                `TCS_A_TCNT: st_nxt.rdata = {15'h0, st_r.tcnt};
                default:     st_nxt.rdata = '0;
            endcase
        end
        if (i_srst) begin
            st_nxt = '0;
            st_nxt.cfg = `TCS_CFG_RST;
            // Twelve hour face never shows zero
            st_nxt.dhour = `TCS_HHALF;
        end
    end

    always_ff @(posedge i_core_clk) begin
        st_r <= st_nxt;
    end

    assign o_rdata       = st_r.rdata;
    assign o_out1        = st_r.o1;
    assign o_out2        = st_r.o2;
    assign o_hour        = st_r.dhour;
    assign o_min         = st_r.mm;
    assign o_sec         = st_r.ss;
    assign o_pm          = st_r.pm;
    assign o_flash       = clk_mode && !st_r.cset;
    assign o_sync_active = clk_mode && st_r.cprev;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    sequence s_cfg_trip;
        i_wr && i_addr == `TCS_A_CFG && !i_wdata[`TCS_CFG_CLOCK] &&
        ((i_wdata[16:0] ^ st_r.cfg) & `TCS_CFG_FSMASK) != '0;
    endsequence
    sequence s_contact_held;
        clk_mode && i_contact ##1 clk_mode && i_contact;
    endsequence

    a_fsafe_entry: assert property (s_cfg_trip and !trst |=>
        st_r.tst == tcs_pkg::TS_FSAFE) else $error("no fail-safe entry");
    a_fsafe_value: assert property (!clk_mode &&
        st_r.tst == tcs_pkg::TS_FSAFE && $past(st_r.tst) == st_r.tst
        |-> st_r.tcnt == (st_r.cfg[`TCS_CFG_DOWN] ? '0 : st_r.sett))
        else $error("fail-safe count wrong");
    a_fsafe_hold: assert property (st_r.tst == tcs_pkg::TS_FSAFE &&
        !clk_mode && i_start && !trst |=> st_r.tst == tcs_pkg::TS_FSAFE)
        else $error("start left fail-safe");
    a_hour_fmt: assert property (!st_r.cfg[`TCS_CFG_FMT24] &&
        $stable(st_r.cfg) |-> o_hour >= 5'h1 && o_hour <= `TCS_HHALF)
        else $error("12 hour value out of range");
    a_lock_gate: assert property (clk_mode && !st_r.cset &&
        !i_contact && !st_r.cprev && !st_r.unlk && !open_code && i_supply_ok
        |=> !st_r.cset) else $error("locked time write accepted");
    a_sync_force: assert property (s_contact_held |->
        {st_r.hh, st_r.mm, st_r.ss} == $past(st_r.sync))
        else $error("sync not forced");
    a_sync_resume: assert property (clk_mode && st_r.cprev &&
        !i_contact && (i_supply_ok || st_r.pf < FW'(PFAIL_CYC - 1))
        |=> st_r.cset)
        else $error("no run-on after sync");
    a_sched_out: assert property (clk_mode && $past(clk_mode) &&
        $rose(st_r.o1) |-> $past(st_r.cfg[`TCS_CFG_EN1]) && st_r.ss == '0)
        else $error("output 1 switched off schedule");
    a_zero_refuse: assert property (!clk_mode &&
        st_r.tst == tcs_pkg::TS_READY && st_r.sett == '0 && !i_wr
        |=> st_r.tst != tcs_pkg::TS_RUN) else $error("zero set started");
    a_unset_stop: assert property (clk_mode && !st_r.cset &&
        !i_contact && !st_r.cprev && !i_wr |=> $stable(st_r.ss))
        else $error("unset clock counted");
    a_supply_loss: assert property (!i_supply_ok &&
        st_r.pf == FW'(PFAIL_CYC - 1) |=> !st_r.cset)
        else $error("supply loss kept time");
endmodule // tcs_top

// File: tb/tcs_contact_model.sv
// Switch contact across the reset terminals
module tcs_contact_model (
    input  wire logic i_core_clk,
    output logic      o_contact
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_contact = 1'b0;

    // Closes for hold repeat_cycle_setting, then opens; hold may be short or long
    task automatic press(input int hold);
        @(posedge i_core_clk);
        o_contact <= 1'b1;
        repeat (hold) @(posedge i_core_clk);
        o_contact <= 1'b0;
    endtask
endmodule // tcs_contact_model

// File: tb/tcs_top_test.sv
// Self-checking bench for the timer and clock supervisor
`include "tcs_regs.svh"
module tcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, srst, wr, rd, start, stop, lrst, supply, contact;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic        out1, out2, pm, flash, sync_act;
    logic [4:0]  hour;
    logic [5:0]  min, sec;
    int          failures, compares, seed, st, b;

    tcs_top #(.TICK_CYC(10), .PFAIL_CYC(8)) uut (
        .i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_start(start), .i_stop(stop),
        .i_local_reset(lrst), .i_contact(contact), .i_supply_ok(supply),
        .o_rdata(rdata), .o_out1(out1), .o_out2(out2), .o_hour(hour),
        .o_min(min), .o_sec(sec), .o_pm(pm), .o_flash(flash),
        .o_sync_active(sync_act));

    tcs_contact_model contact_m (.i_core_clk(clk), .o_contact(contact));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize;
        $display("counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic pulse_start;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic expect_state(input logic [2:0] s, input int n);
        rd_reg(`TCS_A_STAT, d);
        for (int i = 0; i < n && d[2:0] !== s; i++)
            rd_reg(`TCS_A_STAT, d);
        chk("timer state", {29'h0, s}, {29'h0, d[2:0]});
    endtask

    // Select 0 watches output 1, select 1 the seconds' low bit
    task automatic wait_for(input int w, input logic v, input int n);
        for (int i = 0; i < n && (w == 0 ? out1 : sec[0]) !== v; i++) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Outputs are looked at one step after the edge that launched them
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse_lrst;
        @(posedge clk);
        lrst <= 1'b1;
        @(posedge clk);
        lrst <= 1'b0;
    endtask

    // Twelve hour face: midnight shows 12, afternoon wraps
    function automatic logic [4:0] hour12(input logic [4:0] h);
        if (h == 5'h00)
            return 5'h0c;
        return (h > 5'h0c) ? h - 5'h0c : h;
    endfunction

    task automatic do_reset;
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
    endtask

    initial begin
        {wr, rd, start, stop, lrst, addr, wdata} = '0;
        supply = 1'b1;
        srst = 1'b1;
        seed = 32'h034a;
        do_reset();
        // Two seconds at least: one tick may land before the pause
        st = 2 + ($unsigned($random(seed)) % 3);
        pulse_start();
        expect_state(3'h0, 3);
        wr_reg(`TCS_A_SETT, st);
        pulse_start();
        expect_state(3'h1, 3);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        expect_state(3'h2, 3);
        pulse_start();
        expect_state(3'h3, 100);
        rd_reg(`TCS_A_TCNT, d);
        chk("count at end", st, d);
        pulse_start();
        expect_state(3'h3, 3);
        wr_reg(`TCS_A_CFG, 32'h4000);
        pulse_lrst();
        expect_state(3'h0, 5);
        pulse_start();
        expect_state(3'h1, 3);
        // Any guarded setting but the direction, changed while running
        b = 3 + ($unsigned($random(seed)) % 13);
        if (b == 14)
            b = 16;
        wr_reg(`TCS_A_CFG, 32'h4000 | (32'h1 << b));
        expect_state(3'h4, 3);
        rd_reg(`TCS_A_TCNT, d);
        chk("held count", st, d);
        pulse_start();
        expect_state(3'h4, 3);
        contact_m.press(4);
        expect_state(3'h0, 5);
        // Direction change trips while ready; a down count holds zero
        wr_reg(`TCS_A_CFG, 32'h4004);
        expect_state(3'h4, 3);
        rd_reg(`TCS_A_TCNT, d);
        chk("held count", 0, d);
        pulse_lrst();
        pulse_start();
        expect_state(3'h3, 100);
        rd_reg(`TCS_A_TCNT, d);
        chk("count at end", 0, d);
        $display("test timer done");

        do_reset();
        wr_reg(`TCS_A_CFG, 32'h1);
        idle(40);
        chk("o_flash", 1, flash);
        chk("o_sec", 0, sec);
        wr_reg(`TCS_A_TIME, 32'h000d0507);
        idle(3);
        chk("o_hour", hour12(5'h0d), hour);
        chk("o_pm", 1, pm);
        chk("o_flash", 0, flash);
        wr_reg(`TCS_A_CFG, 32'h3);
        idle(3);
        chk("o_hour", 13, hour);
        wr_reg(`TCS_A_CODE, 32'h1234);
        wr_reg(`TCS_A_TIME, 32'h00020000);
        idle(3);
        chk("o_hour", 13, hour);
        wr_reg(`TCS_A_UNLK, 32'h1234);
        wr_reg(`TCS_A_TIME, 32'h000a003a);
        idle(3);
        chk("o_hour", 10, hour);
        // Both outputs on at 10:01, off at 10:02
        wr_reg(`TCS_A_SCHED, 32'h02820281);
        wr_reg(`TCS_A_SCHED + 8'h08, 32'h02820281);
        wr_reg(`TCS_A_CFG, 32'h18003);
        wait_for(0, 1'b1, 100);
        chk("o_out1", 1, out1);
        chk("o_out2", 1, out2);
        wait_for(0, 1'b0, 1000);
        chk("o_out1", 0, out1);
        chk("o_out2", 0, out2);
        $display("test schedule done");

        // Synchronising time 07:30:00
        wr_reg(`TCS_A_SYNC, 32'h00071e00);
        fork
            contact_m.press(20);
            begin
                idle(10);
                chk("o_sync_active", 1, sync_act);
                chk("o_hour", 7, hour);
                chk("o_min", 30, min);
                chk("o_sec", 0, sec);
            end
        join
        wait_for(1, 1'b1, 40);
        chk("o_sec", 1, sec);
        chk("o_min", 30, min);
        supply <= 1'b0;
        idle(12);
        supply <= 1'b1;
        idle(2);
        chk("o_flash", 1, flash);
        // Wrong code relocks; time entry is then refused
        wr_reg(`TCS_A_UNLK, 32'h0);
        wr_reg(`TCS_A_TIME, 32'h00010203);
        idle(3);
        chk("o_flash", 1, flash);
        $display("test clock done");
        summarize();
    end

    // Whole run needs about a thousand repeat_cycle_setting
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule // tcs_top_test
